// File: hdl/touch_key_ctrl.sv
// Touch key scan control: register file on Avalon-MM, per-module counters and scan sequencing.
// Assumes key sense and reference oscillator inputs are synchronous to CLK_I.
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "touch_key_map.svh"

// Functional notes
// - Double key oscillator frequency when enabled.
// - Hop mode picks field or hardware control.
// - Three-bit field picks one of eight settings.
// - Per-module filter enable bit.
// - Slot clock from reference or system/4.
// - Separate reference and key oscillator enables.
// - Key enable hands pin to sensing.
// - Keys grouped four per module.
// - Shared select uses module zero slot timer.
// - One start bit starts every module.
// - Start low clears counters, keeps preload.
// - Start rising switches all counters on.
// - Slot overflow stops oscillators and counters.
// - Single interrupt on slot overflow, enabled keys.
// - Counters cleared automatically after interrupt.
// - Count sense cycles, interrupt at end.
// - Measurement period from programmable divider.
// - Rising start enables oscillators together.
// - Period is (256 - preload) times 32.
// - Overflow flag set by hardware only.
// - Mux field picks measured key.
module touch_key_ctrl
  import touch_key_pkg::*;
#(
  parameter int NUM_MOD = 4
)
(
  input  wire logic                 CLK_I,
  input  wire logic                 RST_I,
  input  wire logic [7:0]           ADDRESS_I,
  input  wire logic                 READ_I,
  input  wire logic                 WRITE_I,
  input  wire logic [31:0]          WRITEDATA_I,
  input  wire logic [3:0]           BYTEENABLE_I,
  output logic      [31:0]          READDATA_O,
  output logic                      WAITREQUEST_O,
  input  wire logic [4*NUM_MOD-1:0] KEY_SENSE_I,
  input  wire logic [NUM_MOD-1:0]   REF_OSC_I,
  output logic      [4*NUM_MOD-1:0] KEY_PIN_SEL_O,
  output logic      [NUM_MOD-1:0]   REF_OSC_EN_O,
  output logic      [NUM_MOD-1:0]   KEY_OSC_EN_O,
  output logic      [NUM_MOD-1:0]   FREQ_DOUBLE_O,
  output logic      [NUM_MOD-1:0]   FILTER_EN_O,
  output logic      [3*NUM_MOD-1:0] HOP_SEL_O,
  output logic                      TOUCH_IRQ_O
);

  ctrl0_t              ctrl0_q [NUM_MOD];
  ctrl1_t              ctrl1_q [NUM_MOD];
  logic [7:0]          slot_preload_q;
  logic                scan_start_q;
  logic                shared_slot_sel_q;
  logic                slot_overflow_flag_q;
  scan_state_t         state_q;
  logic [1:0]          sys_div_q;
  logic                sys_tick;
  logic [15:0]         ref_cnt_q;
  logic [15:0]         ref_res_q;
  logic [2:0]          hop_hw_q;
  logic [NUM_MOD-1:0]  run_q;
  logic [NUM_MOD-1:0]  part;
  logic [NUM_MOD-1:0]  ovf;
  logic [NUM_MOD-1:0]  ref_prev_q;
  logic [4*NUM_MOD-1:0] key_prev_q;
  logic [15:0]         cyc_cnt_q [NUM_MOD];
  logic [15:0]         cyc_res_q [NUM_MOD];
  logic                req;
  logic                wr_take;
  logic                start_rise;
  logic                start_fall;
  logic                scan_done;
  logic                clr_cnt;
  logic                flag_clr;
  logic [3:0]          grp;
  logic [1:0]          idx;
  logic [31:0]         rd_d;

  assign req     = READ_I || WRITE_I;
  assign wr_take = WRITE_I && !WAITREQUEST_O && BYTEENABLE_I[0];
  assign grp     = ADDRESS_I[7:4];
  assign idx     = ADDRESS_I[3:2];

  assign start_rise = wr_take && ADDRESS_I == `TK_GCTRL_OFS && !scan_start_q && WRITEDATA_I[`TK_START_BIT];
  assign start_fall = wr_take && ADDRESS_I == `TK_GCTRL_OFS && scan_start_q && !WRITEDATA_I[`TK_START_BIT];
  assign flag_clr   = wr_take && ADDRESS_I == `TK_GCTRL_OFS && !WRITEDATA_I[`TK_OVF_BIT];

  // end when every participating module stopped
  assign scan_done = state_q == ST_RUN && (run_q & part) == '0;
  assign clr_cnt   = start_fall || scan_done;

  // Answer one cycle after the request; the write lands on the edge the master sees waitrequest low.
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      WAITREQUEST_O <= 1'b1;
    else if (req && WAITREQUEST_O)
      WAITREQUEST_O <= 1'b0;
    else
      WAITREQUEST_O <= 1'b1;
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (ADDRESS_I[1:0] == 2'h0)
    begin
      if (ADDRESS_I == `TK_GCTRL_OFS)
      begin
        rd_d[`TK_SHARED_BIT] = shared_slot_sel_q;
        rd_d[`TK_START_BIT]  = scan_start_q;
        rd_d[`TK_OVF_BIT]    = slot_overflow_flag_q;
      end
      else if (ADDRESS_I == `TK_PRELOAD_OFS)
        rd_d[7:0] = slot_preload_q;
      else if (ADDRESS_I == `TK_REFCNT_OFS)
        rd_d[15:0] = ref_res_q;
      else if (32'(idx) < NUM_MOD)
      begin
        if (grp == `TK_GRP_CTRL0)
          rd_d[7:0] = ctrl0_q[idx];
        else if (grp == `TK_GRP_CTRL1)
          rd_d[7:0] = {ctrl1_q[idx].slot_clk_sel, 1'b0, ctrl1_q[idx][5:0]};
        else if (grp == `TK_GRP_CYCLE)
          rd_d[15:0] = cyc_res_q[idx];
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      READDATA_O <= 32'h0000_0000;
    else if (READ_I && WAITREQUEST_O)
      READDATA_O <= rd_d;
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      slot_preload_q    <= `TK_PRELOAD_RST;
      scan_start_q      <= 1'b0;
      shared_slot_sel_q <= 1'b0;
    end
    else if (wr_take && ADDRESS_I == `TK_GCTRL_OFS)
    begin
      scan_start_q      <= WRITEDATA_I[`TK_START_BIT];
      shared_slot_sel_q <= WRITEDATA_I[`TK_SHARED_BIT];
    end
    else if (wr_take && ADDRESS_I == `TK_PRELOAD_OFS)
      slot_preload_q <= WRITEDATA_I[7:0];
  end

  // hardware set wins over software clear
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      slot_overflow_flag_q <= 1'b0;
    else if (scan_done)
      slot_overflow_flag_q <= 1'b1;
    else if (flag_clr)
      slot_overflow_flag_q <= 1'b0;
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      state_q <= ST_IDLE;
    else if (start_fall)
      state_q <= ST_IDLE;
    else if (start_rise)
      state_q <= ST_RUN;
    else if (scan_done)
      state_q <= ST_DONE;
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      sys_div_q <= 2'h0;
    else
      sys_div_q <= sys_div_q + 2'h1;
  end
  assign sys_tick = sys_div_q == `TK_SYS_DIV_LAST;

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      ref_cnt_q <= 16'h0000;
    else if (clr_cnt || start_rise)
      ref_cnt_q <= 16'h0000;
    else if (state_q == ST_RUN)
      ref_cnt_q <= ref_cnt_q + 16'h0001;
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      ref_res_q <= 16'h0000;
    else if (start_fall)
      ref_res_q <= 16'h0000;
    else if (scan_done)
      ref_res_q <= ref_cnt_q;
  end

  // hardware hopping steps once per scan
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      hop_hw_q <= `TK_HOP_RST;
    else if (scan_done)
      hop_hw_q <= hop_hw_q + 3'h1;
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      TOUCH_IRQ_O <= 1'b0;
    else
      TOUCH_IRQ_O <= scan_done;
  end

  generate
    for (genvar m = 0; m < NUM_MOD; m++)
    begin : g_mod
      logic       slot_tick;
      logic       mod_ovf;
      logic       key_edge;
      logic [1:0] sel;
      logic       osc_on;
      localparam logic [3:0] C0_IDX = 4'(m);

      assign sel = ctrl0_q[m].key_mux_sel;
      // only modules with enabled keys take part
      assign part[m] = |ctrl1_q[m].key_en;
      assign slot_tick = ctrl1_q[m].slot_clk_sel ? sys_tick : (REF_OSC_I[m] && !ref_prev_q[m]);
      // shared slot timer from module zero
      assign mod_ovf = shared_slot_sel_q ? ovf[0] : ovf[m];
      assign key_edge = KEY_SENSE_I[4*m+sel] && !key_prev_q[4*m+sel] && ctrl1_q[m].key_en[sel]
                        && ctrl1_q[m].key_osc_en;
      assign osc_on = state_q == ST_RUN && run_q[m];

      always_ff @(posedge CLK_I or posedge RST_I)
      begin
        if (RST_I)
        begin
          ctrl0_q[m] <= `TK_CTRL0_RST;
          ctrl1_q[m] <= `TK_CTRL1_RST;
        end
        else if (wr_take && ADDRESS_I[1:0] == 2'h0 && idx == C0_IDX[1:0])
        begin
          if (grp == `TK_GRP_CTRL0)
            ctrl0_q[m] <= WRITEDATA_I[7:0];
          else if (grp == `TK_GRP_CTRL1)
            ctrl1_q[m] <= {WRITEDATA_I[7], 1'b0, WRITEDATA_I[5:0]};
        end
      end

      always_ff @(posedge CLK_I or posedge RST_I)
      begin
        if (RST_I)
        begin
          ref_prev_q[m]         <= 1'b0;
          key_prev_q[4*m +: 4]  <= 4'h0;
        end
        else
        begin
          ref_prev_q[m]         <= REF_OSC_I[m];
          key_prev_q[4*m +: 4]  <= KEY_SENSE_I[4*m +: 4];
        end
      end

      // module stops at its slot overflow, or at module zero's when the shared select is set
      always_ff @(posedge CLK_I or posedge RST_I)
      begin
        if (RST_I)
          run_q[m] <= 1'b0;
        else if (start_rise)
          run_q[m] <= 1'b1;
        else if (start_fall || mod_ovf)
          run_q[m] <= 1'b0;
      end

      touch_slot_timer u_slot (
        .clk_i     (CLK_I),
        .rst_i     (RST_I),
        .arm_i     (start_rise),
        .clear_i   (clr_cnt),
        .run_i     (osc_on),
        .tick_i    (slot_tick),
        .preload_i (slot_preload_q),
        .ovf_o     (ovf[m])
      );

      always_ff @(posedge CLK_I or posedge RST_I)
      begin
        if (RST_I)
          cyc_cnt_q[m] <= 16'h0000;
        else if (clr_cnt || start_rise)
          cyc_cnt_q[m] <= 16'h0000;
        else if (osc_on && key_edge)
          cyc_cnt_q[m] <= cyc_cnt_q[m] + 16'h0001;
      end

      // The live counter is wiped after the interrupt, so its value is kept here for software.
      always_ff @(posedge CLK_I or posedge RST_I)
      begin
        if (RST_I)
          cyc_res_q[m] <= 16'h0000;
        else if (start_fall)
          cyc_res_q[m] <= 16'h0000;
        else if (scan_done)
          cyc_res_q[m] <= cyc_cnt_q[m];
      end

      always_ff @(posedge CLK_I or posedge RST_I)
      begin
        if (RST_I)
        begin
          REF_OSC_EN_O[m]       <= 1'b0;
          KEY_OSC_EN_O[m]       <= 1'b0;
          FREQ_DOUBLE_O[m]      <= 1'b0;
          FILTER_EN_O[m]        <= 1'b0;
          HOP_SEL_O[3*m +: 3]   <= `TK_HOP_RST;
          KEY_PIN_SEL_O[4*m +: 4] <= 4'h0;
        end
        else
        begin
          REF_OSC_EN_O[m]       <= osc_on && ctrl1_q[m].ref_osc_en;
          KEY_OSC_EN_O[m]       <= osc_on && ctrl1_q[m].key_osc_en;
          FREQ_DOUBLE_O[m]      <= ctrl0_q[m].freq_double_en;
          FILTER_EN_O[m]        <= ctrl0_q[m].filter_en;
          HOP_SEL_O[3*m +: 3]   <= ctrl0_q[m].hop_hw_ctrl ? hop_hw_q : ctrl0_q[m].hop_freq_sel;
          KEY_PIN_SEL_O[4*m +: 4] <= ctrl1_q[m].key_en;
        end
      end
    end
  endgenerate

endmodule : touch_key_ctrl
`default_nettype wire

// File: shared/touch_key_map.svh
// Register offsets, field positions, reset values and timing counts of the touch key scan block.
// Assumes byte addresses on a 32-bit Avalon-MM slave, one register per aligned word.
`ifndef TOUCH_KEY_MAP_SVH
`define TOUCH_KEY_MAP_SVH

`define TK_GCTRL_OFS     8'h00
`define TK_PRELOAD_OFS   8'h04
`define TK_REFCNT_OFS    8'h08
`define TK_GRP_CTRL0     4'h1
`define TK_GRP_CTRL1     4'h2
`define TK_GRP_CYCLE     4'h3

`define TK_SHARED_BIT    2
`define TK_START_BIT     5
`define TK_OVF_BIT       6

`define TK_CTRL0_RST     8'h00
`define TK_CTRL1_RST     8'h00
`define TK_PRELOAD_RST   8'h00
`define TK_HOP_RST       3'h0

`define TK_SYS_DIV_LAST  2'h3
`define TK_FRAC_LAST     5'h1F
`define TK_WHOLE_LAST    8'hFF

`endif

// File: shared/touch_key_pkg.sv
// Types shared by the touch key scan control and its slot timer.
// Field order follows the per-module control registers, bit 7 first.
package touch_key_pkg;

  typedef struct packed {
    logic [1:0] key_mux_sel;
    logic       freq_double_en;
    logic       filter_en;
    logic       hop_hw_ctrl;
    logic [2:0] hop_freq_sel;
  } ctrl0_t;

  typedef struct packed {
    logic       slot_clk_sel;
    logic       unused6;
    logic       ref_osc_en;
    logic       key_osc_en;
    logic [3:0] key_en;
  } ctrl1_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } scan_state_t;

endpackage : touch_key_pkg

// File: hdl/touch_slot_timer.sv
// Time-slot counter of one touch module: a 5-bit prescaler feeding an 8-bit preloadable counter.
// Assumes tick_i is a one-cycle slot clock enable and that arm_i and clear_i never overlap.
`timescale 1ns/1ps
`default_nettype none
`include "touch_key_map.svh"

module touch_slot_timer
  import touch_key_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       arm_i,
  input  wire logic       clear_i,
  input  wire logic       run_i,
  input  wire logic       tick_i,
  input  wire logic [7:0] preload_i,
  output logic            ovf_o
);

  logic [4:0] frac_q;
  logic [7:0] whole_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      frac_q <= 5'h00;
    else if (clear_i || arm_i)
      frac_q <= 5'h00;
    else if (run_i && tick_i)
      frac_q <= frac_q + 5'h01;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      whole_q <= 8'h00;
    else if (arm_i)
      whole_q <= preload_i;
    else if (run_i && tick_i && frac_q == `TK_FRAC_LAST)
      whole_q <= whole_q + 8'h01;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ovf_o <= 1'b0;
    else
      ovf_o <= run_i && tick_i && frac_q == `TK_FRAC_LAST && whole_q == `TK_WHOLE_LAST;
  end

endmodule : touch_slot_timer
`default_nettype wire

// File: dv/touch_pad_model.sv
// Touch pads and reference oscillators on the sense side of the scan control.
// Assumes the enables come from registers clocked by the system clock.
`timescale 1ns/1ps
`default_nettype none

module touch_pad_model
(
  input  wire logic [15:0] pin_sel_i,
  input  wire logic        clk_i,
  input  wire logic [3:0]  key_osc_en_i,
  input  wire logic [3:0]  ref_osc_en_i,
  input  wire logic [3:0]  dbl_i,
  output logic      [15:0] sense_o,
  output logic      [3:0]  ref_o
);
  logic [7:0] tick_q = 8'h00;

  initial
  begin
    sense_o = 16'h0000;
    ref_o   = 4'h0;
  end

  always @(posedge clk_i)
  begin
    tick_q <= tick_q + 8'h01;
    // Key k of module m sits on line 4m+k.
    // A pin left to port use chatters every cycle, so a miscount shows.
    for (int i = 0; i < 16; i++)
      sense_o[i] <= (pin_sel_i[i] && key_osc_en_i[i / 4]) ? tick_q[(i % 4) + 1 - int'(dbl_i[i / 4])] : ~sense_o[i];
    for (int m = 0; m < 4; m++)
      ref_o[m] <= ref_osc_en_i[m] && tick_q[2];
  end
endmodule : touch_pad_model
`default_nettype wire

// File: dv/touch_key_ctrl_monitor.sv
// Port checker for the touch key scan control.
// Assumes it is bound into the design and sees one clock domain.
`timescale 1ns/1ps
`default_nettype none

module touch_key_ctrl_monitor
#(
  parameter int NUM_MOD = 4
)
(
  input wire logic                 CLK_I,
  input wire logic                 RST_I,
  input wire logic [7:0]           ADDRESS_I,
  input wire logic                 READ_I,
  input wire logic                 WRITE_I,
  input wire logic [31:0]          WRITEDATA_I,
  input wire logic [3:0]           BYTEENABLE_I,
  input wire logic                 WAITREQUEST_O,
  input wire logic [4*NUM_MOD-1:0] KEY_PIN_SEL_O,
  input wire logic [NUM_MOD-1:0]   REF_OSC_EN_O,
  input wire logic [NUM_MOD-1:0]   KEY_OSC_EN_O,
  input wire logic [NUM_MOD-1:0]   FREQ_DOUBLE_O,
  input wire logic [NUM_MOD-1:0]   FILTER_EN_O,
  input wire logic                 TOUCH_IRQ_O
);
  logic cfg_wr;
  logic go_start;
  logic go_stop;

  assign cfg_wr   = WRITE_I && !WAITREQUEST_O && BYTEENABLE_I[0];
  assign go_start = cfg_wr && ADDRESS_I == 8'h00 && WRITEDATA_I[5];
  assign go_stop  = cfg_wr && ADDRESS_I == 8'h00 && !WRITEDATA_I[5];

  default clocking mon_cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  a_wait_answer: assert property ((READ_I || WRITE_I) && WAITREQUEST_O |=> !WAITREQUEST_O ##1 WAITREQUEST_O)
    else $error("bus answer out of step");
  a_irq_one_pulse: assert property (TOUCH_IRQ_O |=> !TOUCH_IRQ_O)
    else $error("interrupt wider than one cycle");
  a_irq_osc_off: assert property (TOUCH_IRQ_O |-> {REF_OSC_EN_O, KEY_OSC_EN_O} == '0 ##1 {REF_OSC_EN_O, KEY_OSC_EN_O} == '0)
    else $error("oscillator running at interrupt");
  a_key_osc_start: assert property ($rose(|KEY_OSC_EN_O) |-> $past(go_start, 2))
    else $error("key oscillator started without start");
  a_ref_osc_sync: assert property ((REF_OSC_EN_O & ~$past(REF_OSC_EN_O)) != '0 |-> $past(go_start, 2))
    else $error("reference oscillator started out of step");
  a_pin_sel_follow: assert property ($changed(KEY_PIN_SEL_O) |-> $past(cfg_wr, 2))
    else $error("pin selection moved without a write");
  a_dbl_filt_follow: assert property ($changed({FREQ_DOUBLE_O, FILTER_EN_O}) |-> $past(cfg_wr, 2))
    else $error("doubling or filter moved without a write");
  a_stop_clears: assert property (go_stop |-> ##2 {REF_OSC_EN_O, KEY_OSC_EN_O} == '0)
    else $error("oscillators kept after stop");
endmodule : touch_key_ctrl_monitor

bind touch_key_ctrl touch_key_ctrl_monitor #(.NUM_MOD(NUM_MOD)) mon
(
  .CLK_I(CLK_I), .RST_I(RST_I), .ADDRESS_I(ADDRESS_I), .READ_I(READ_I), .WRITE_I(WRITE_I),
  .WRITEDATA_I(WRITEDATA_I), .BYTEENABLE_I(BYTEENABLE_I), .WAITREQUEST_O(WAITREQUEST_O),
  .KEY_PIN_SEL_O(KEY_PIN_SEL_O), .REF_OSC_EN_O(REF_OSC_EN_O), .KEY_OSC_EN_O(KEY_OSC_EN_O),
  .FREQ_DOUBLE_O(FREQ_DOUBLE_O), .FILTER_EN_O(FILTER_EN_O), .TOUCH_IRQ_O(TOUCH_IRQ_O)
);
`default_nettype wire

// File: dv/capacitive_key_scan_control_tb_top.sv
// Self-checking bench for the touch key scan control with pad models on its sense pins.
// Assumes the design register map and a 100 MHz system clock.
`timescale 1ns/1ps
`default_nettype none

module capacitive_key_scan_control_tb_top;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic [7:0]  addr  = 8'h00;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be    = 4'hF;
  logic [31:0] rdata;
  logic        busy;
  logic [15:0] sense;
  logic [3:0]  refo;
  logic [15:0] psel;
  logic [3:0]  ren;
  logic [3:0]  ken;
  logic [3:0]  dbl;
  logic [3:0]  filt;
  logic [11:0] hop;
  logic        irq;
  logic [31:0] d;
  int          mismatches = 0;
  int          checks     = 0;
  int          cyc        = 0;
  int          irqs       = 0;

  touch_key_ctrl DUT
  (
    .CLK_I(clk), .RST_I(rst), .ADDRESS_I(addr), .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wdata),
    .BYTEENABLE_I(be), .READDATA_O(rdata), .WAITREQUEST_O(busy), .KEY_SENSE_I(sense), .REF_OSC_I(refo),
    .KEY_PIN_SEL_O(psel), .REF_OSC_EN_O(ren), .KEY_OSC_EN_O(ken), .FREQ_DOUBLE_O(dbl),
    .FILTER_EN_O(filt), .HOP_SEL_O(hop), .TOUCH_IRQ_O(irq)
  );

  touch_pad_model pads
  (
    .pin_sel_i(psel), .clk_i(clk), .key_osc_en_i(ken), .ref_osc_en_i(ren), .dbl_i(dbl),
    .sense_o(sense), .ref_o(refo)
  );

  always #5 clk = ~clk;

  // The longest scan window is 512 cycles, so this only cuts a hang.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (irq === 1'b1)
      irqs <= irqs + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    checks++;
    if ((^got === 1'bx) || got < 32'(lo) || got > 32'(hi))
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h lo=%h hi=%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // Requests are held until wait request is seen low at a rising edge.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    do @(posedge clk); while (busy !== 1'b0);
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd   <= 1'b1;
    do @(posedge clk); while (busy !== 1'b0);
    v = rdata;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus_rd

  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask : wait_irq

  task automatic t_regs;
    for (int m = 0; m < 4; m++)
    begin
      bus_rd(8'h10 + 8'(4 * m), d);
      chk(d, 32'h0); // Control zero is clear.
      bus_wr(8'h20 + 8'(4 * m), 32'hFF);
      bus_rd(8'h20 + 8'(4 * m), d);
      chk(d, 32'hBF); // Spare bit reads zero.
      bus_wr(8'h10 + 8'(4 * m), 32'h30);
      bus_rd(8'h10 + 8'(4 * m), d);
      chk({28'h0, psel[4 * m +: 4]}, 32'hF); // Pins go to sensing.
      chk({30'h0, dbl[m], filt[m]}, 32'h3); // Doubling and filter.
    end
    bus_rd(8'hFC, d);
    chk(d, 32'h0);
    bus_rd(8'h04, d);
    chk(d, 32'h0); // Preload starts clear.
  endtask : t_regs

  task automatic t_hop;
    for (int c = 0; c < 8; c++)
    begin
      bus_wr(8'h10, 32'(c));
      bus_rd(8'h10, d);
      chk({29'h0, hop[2:0]}, 32'(c)); // Field picks setting.
    end
    // No scan has ended yet, so the hardware hop value is still its reset value.
    bus_wr(8'h10, 32'h0D);
    bus_rd(8'h10, d);
    chk({29'h0, hop[2:0]}, 32'h0); // Hardware value wins.
    bus_wr(8'h10, 32'h0A);
    bus_rd(8'h10, d);
    chk({29'h0, hop[2:0]}, 32'h0); // Field is ignored.
  endtask : t_hop

  // Module 1 doubles and runs off its reference; module 2 has its key oscillator off.
  task automatic t_scan(input logic shared, input int w, input int c1);
    int t;
    int n0;
    for (int m = 0; m < 4; m++)
    begin
      bus_wr(8'h10 + 8'(4 * m), {24'h0, 2'(m), m == 1, 5'h0});
      bus_wr(8'h20 + 8'(4 * m), {24'h0, m != 1, 2'b01, m != 2, (m == 3) ? 4'h7 : 4'hF});
    end
    bus_wr(8'h04, 32'hFE);
    n0 = irqs;
    bus_wr(8'h00, {26'h0, 3'b100, shared, 2'b00}); // Configured before start.
    wait_irq(t);
    chk_rng(32'(t), w - 4, w + 16); // Window length.
    bus_rd(8'h00, d);
    chk({31'h0, d[6]}, 32'h1); // Flag set by overflow.
    bus_rd(8'h30, d);
    chk_rng(d, 61, 67); // First key counted.
    bus_rd(8'h34, d);
    chk_rng(d, c1 - 3, c1 + 3); // Doubled key counted.
    bus_rd(8'h38, d);
    chk(d, 32'h0); // Key oscillator off.
    bus_rd(8'h3C, d);
    chk(d, 32'h0); // Selected key disabled.
    bus_rd(8'h08, d);
    chk_rng(d, w - 8, w + 16); // Reference count.
    chk(32'(irqs - n0), 32'h1); // One interrupt.
    bus_wr(8'h00, 32'h0);
    bus_rd(8'h30, d);
    chk(d, 32'h0); // Stop clears counts.
    bus_wr(8'h00, 32'h40);
    bus_rd(8'h00, d);
    chk({31'h0, d[6]}, 32'h0); // Software cannot set.
  endtask : t_scan

  task automatic t_abort;
    int n0;
    n0 = irqs;
    bus_wr(8'h00, 32'h24);
    repeat (40) @(posedge clk);
    bus_wr(8'h00, 32'h0);
    bus_rd(8'h30, d);
    chk(d, 32'h0); // Abort clears counts.
    repeat (600) @(posedge clk);
    chk(32'(irqs - n0), 32'h0); // No late interrupt.
  endtask : t_abort

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_hop();
    t_scan(1'b1, 256, 64); // Module zero slot rules.
    t_scan(1'b0, 512, 128); // Own reference slot.
    t_abort();
    close_out();
  end
endmodule : capacitive_key_scan_control_tb_top
`default_nettype wire
